// *** rtl/mos_pkg.sv ***
package mos_pkg;
   localparam int WORD_W          = 12;
   localparam int MAX_CH          = 4;
   localparam int LATENCY_CYC     = 5;
   localparam int MARKER_BASE_CYC = 7;
   localparam logic [11:0] CODE_BIN_FULL = 12'hFFF;
   localparam logic [11:0] CODE_BIN_MID  = 12'h800;
   localparam logic [11:0] CODE_BIN_ZERO = 12'h000;
   localparam logic [11:0] CODE_TC_FLIP  = 12'h800;
   localparam logic [11:0] DATA_RESET    = 12'h000;
   localparam int RATE_MAX_KSPS   = 6000;
   localparam int CLK_HZ          = 25000000;
   localparam int MIN_CONV_PERIOD_CYC = (CLK_HZ + RATE_MAX_KSPS * 1000 - 1) / (RATE_MAX_KSPS * 1000);
endpackage

// *** rtl/mos_sequencer.sv ***
`timescale 1ns/1ns
module mos_sequencer
   import mos_pkg::*;
(
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   // link pins
   input  wire logic              conversion_clock_in,
   input  wire logic              select_active_low_n_in,
   input  wire logic              select_active_high_in,
   input  wire logic              read_n_in,
   input  wire logic              marker_reset_in,
   // configuration
   input  wire logic [1:0]        chan_count_m1_in,
   input  wire logic              twos_comp_in,
   // sampled channel codes, binary
   input  wire logic [4*WORD_W-1:0] sample_codes_in,
   // data bus
   output logic [WORD_W-1:0]      data_out,
   output logic                   data_oe_n_out,
   output logic                   marker_n_out,
   output logic                   marker_oe_n_out
);
   logic [2:0]        pin_sync;
   logic              conv_s;
   logic              conv_d_reg;
   logic              conv_fall;
   logic              strobe;
   logic [WORD_W-1:0] pipe_reg [LATENCY_CYC];
   logic [1:0]        chan_pipe_reg [LATENCY_CYC];
   logic [4*WORD_W-1:0] hold_reg;
   logic [1:0]        slot_reg;
   logic [3:0]        marker_wait_reg;
   logic              marker_armed_reg;
   logic              multi;
   logic [WORD_W-1:0] out_word;

   mos_sync2 #(.W(3)) u_sync
   (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   ({conversion_clock_in, select_active_low_n_in, select_active_high_in}),
      .q_out  (pin_sync)
   );
   logic read_s;
   mos_sync2 #(.W(1)) u_sync_rd
   (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   (read_n_in),
      .q_out  (read_s)
   );

   assign conv_s    = pin_sync[2];
   assign conv_fall = conv_d_reg & ~conv_s;
   assign strobe    = ~pin_sync[1] & pin_sync[0] & ~read_s;
   assign multi     = chan_count_m1_in != 2'd0;

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         conv_d_reg <= 1'b0;
      else
         conv_d_reg <= conv_s;
   end

   // slot counter, samples latched at slot zero
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         slot_reg <= 2'd0;
         hold_reg <= '0;
      end
      // restart so channel one leaves the pipe on the marker count
      else if (marker_reset_in)
         slot_reg <= chan_count_m1_in - 2'd1;
      else if (conv_fall)
      begin
         if (slot_reg >= chan_count_m1_in)
         begin
            slot_reg <= 2'd0;
            hold_reg <= sample_codes_in;
         end
         else
            slot_reg <= slot_reg + 2'd1;
      end
   end

   // five-stage pipeline of words and channel tags
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < LATENCY_CYC; i++)
         begin
            pipe_reg[i]      <= DATA_RESET;
            chan_pipe_reg[i] <= 2'd0;
         end
      end
      else if (conv_fall)
      begin
         pipe_reg[0]      <= (slot_reg >= chan_count_m1_in) ? sample_codes_in[WORD_W-1:0]
                             : hold_reg[WORD_W*(slot_reg+2'd1) +: WORD_W];
         chan_pipe_reg[0] <= (slot_reg >= chan_count_m1_in) ? 2'd0 : slot_reg + 2'd1;
         for (int i = 1; i < LATENCY_CYC; i++)
         begin
            pipe_reg[i]      <= pipe_reg[i-1];
            chan_pipe_reg[i] <= chan_pipe_reg[i-1];
         end
      end
   end

   assign out_word = twos_comp_in ? (pipe_reg[LATENCY_CYC-1] ^ CODE_TC_FLIP)
                                  : pipe_reg[LATENCY_CYC-1];

   // output word and bus enable
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         data_out      <= DATA_RESET;
         data_oe_n_out <= 1'b1;
      end
      else
      begin
         if (conv_fall)
            data_out <= out_word;
         data_oe_n_out <= ~strobe;
      end
   end

   // marker: held off after marker_reset_in for base plus channel count edges
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         marker_wait_reg  <= 4'd0;
         marker_armed_reg <= 1'b0;
         marker_n_out     <= 1'b1;
         marker_oe_n_out  <= 1'b1;
      end
      else if (marker_reset_in)
      begin
         marker_wait_reg  <= 4'(MARKER_BASE_CYC) + {2'b00, chan_count_m1_in} + 4'd1;
         marker_armed_reg <= 1'b0;
         marker_n_out     <= 1'b1;
      end
      else
      begin
         marker_oe_n_out <= ~multi;
         if (conv_fall)
         begin
            if (marker_wait_reg > 4'd1)
               marker_wait_reg <= marker_wait_reg - 4'd1;
            else
               marker_armed_reg <= 1'b1;
            marker_n_out <= ~(multi && (marker_armed_reg || marker_wait_reg == 4'd1)
                              && chan_pipe_reg[LATENCY_CYC-1] == 2'd0);
         end
      end
   end

   property p_oe_follows_strobe;
      @(posedge clk_in) disable iff (rst_in)
      strobe |=> !data_oe_n_out;
   endproperty
   a_oe_follows_strobe: assert property (p_oe_follows_strobe) else $error("bus not driven on read");

   property p_idle_hiz;
      @(posedge clk_in) disable iff (rst_in)
      !strobe |=> data_oe_n_out;
   endproperty
   a_idle_hiz: assert property (p_idle_hiz) else $error("bus driven without read");

   property p_single_marker_off;
      @(posedge clk_in) disable iff (rst_in)
      (!multi && !marker_reset_in) |=> marker_oe_n_out && marker_n_out;
   endproperty
   a_single_marker_off: assert property (p_single_marker_off) else $error("marker active in single mode");

   property p_word_update;
      @(posedge clk_in) disable iff (rst_in)
      conv_fall |=> data_out == $past(out_word);
   endproperty
   a_word_update: assert property (p_word_update) else $error("word not updated at edge");

   property p_marker_chan_one;
      @(posedge clk_in) disable iff (rst_in)
      (conv_fall && !marker_reset_in && chan_pipe_reg[LATENCY_CYC-1] != 2'd0) |=> marker_n_out;
   endproperty
   a_marker_chan_one: assert property (p_marker_chan_one) else $error("marker on wrong channel");

   property p_marker_held_off;
      @(posedge clk_in) disable iff (rst_in)
      marker_reset_in |=> marker_n_out && !marker_armed_reg;
   endproperty
   a_marker_held_off: assert property (p_marker_held_off) else $error("marker not reset");

   property p_slot_wrap;
      @(posedge clk_in) disable iff (rst_in)
      (conv_fall && !marker_reset_in && slot_reg >= chan_count_m1_in) |=> slot_reg == 2'd0;
   endproperty
   a_slot_wrap: assert property (p_slot_wrap) else $error("slot did not wrap");

   property p_slot_step;
      @(posedge clk_in) disable iff (rst_in)
      (conv_fall && !marker_reset_in && slot_reg < chan_count_m1_in) |=> slot_reg == $past(slot_reg) + 2'd1;
   endproperty
   a_slot_step: assert property (p_slot_step) else $error("slot did not advance");

   property p_slot_restart;
      @(posedge clk_in) disable iff (rst_in)
      marker_reset_in |=> slot_reg == $past(chan_count_m1_in) - 2'd1;
   endproperty
   a_slot_restart: assert property (p_slot_restart) else $error("slot not restarted");

   property p_format;
      @(posedge clk_in) disable iff (rst_in)
      conv_fall |=> data_out == {$past(pipe_reg[LATENCY_CYC-1][WORD_W-1]) ^ $past(twos_comp_in),
                                 $past(pipe_reg[LATENCY_CYC-1][WORD_W-2:0])};
   endproperty
   a_format: assert property (p_format) else $error("output coding wrong");
endmodule // mos_sequencer

// *** rtl/mos_sync2.sv ***
`timescale 1ns/1ns
module mos_sync2 #(parameter int W = 1)
(
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   // async in, synced out
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_reg <= '0;
         q_out    <= '0;
      end
      else
      begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end
endmodule // mos_sync2

// *** verif/mos_host_model.sv ***
`timescale 1ns/1ns
module mos_host_model
(
   // clock
   input  wire logic       clk_in,
   // strobe terms wanted: select low, select high, read
   input  wire logic [2:0] terms_in,
   // device pins
   output logic            conversion_clock_out,
   output logic            select_active_low_n_out,
   output logic            select_active_high_out,
   output logic            read_n_out
);
   initial
   begin
      conversion_clock_out = 1'b1;
      #7;
      // 50% duty, 2.5 MHz keeps under the rate ceiling
      forever #200 conversion_clock_out = ~conversion_clock_out;
   end

   initial
   begin
      select_active_low_n_out = 1'b1;
      select_active_high_out  = 1'b0;
      // no read at start: the opening write goes to control logic outside this block
      read_n_out              = 1'b1;
   end

   always @(posedge clk_in)
   begin
      select_active_low_n_out <= ~terms_in[0];
      select_active_high_out  <= terms_in[1];
      read_n_out              <= ~terms_in[2];
   end
endmodule // mos_host_model

// *** verif/multichannel_adc_output_sequencer_tb.sv ***
`timescale 1ns/1ns
module multichannel_adc_output_sequencer_tb;
   import mos_pkg::*;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        marker_reset_in = 1'b0;
   logic [1:0]  chan_count_m1_in = 2'h0;
   logic        twos_comp_in = 1'b0;
   logic [47:0] sample_codes_in = '0;
   logic [2:0]  terms = 3'h0;
   logic        conv, sel_l_n, sel_h, rd_n, oe_n, mark_n, mark_oe_n;
   logic [11:0] data;
   int          errors = 0;
   int          total_checks = 0;
   int          cycles = 0;

   always #20 clk_in = ~clk_in;

   mos_host_model host (.clk_in(clk_in), .terms_in(terms), .conversion_clock_out(conv),
      .select_active_low_n_out(sel_l_n), .select_active_high_out(sel_h), .read_n_out(rd_n));

   mos_sequencer dut (.clk_in(clk_in), .rst_in(rst_in), .conversion_clock_in(conv),
      .select_active_low_n_in(sel_l_n), .select_active_high_in(sel_h), .read_n_in(rd_n),
      .marker_reset_in(marker_reset_in), .chan_count_m1_in(chan_count_m1_in),
      .twos_comp_in(twos_comp_in), .sample_codes_in(sample_codes_in), .data_out(data),
      .data_oe_n_out(oe_n), .marker_n_out(mark_n), .marker_oe_n_out(mark_oe_n));

   task automatic end_sim;
      if (errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         errors++;
         end_sim();
      end
   end

   task automatic check(input logic [11:0] got, input logic [11:0] exp, input string msg);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // settle point after the synced fall has landed
   task automatic falls(input int n);
      repeat (n)
      begin
         @(negedge conv);
         repeat (6) @(posedge clk_in);
         #1;
      end
   endtask

   task automatic do_reset(input logic [1:0] n_m1);
      chan_count_m1_in = n_m1;
      rst_in = 1'b1;
      repeat (4) @(posedge clk_in);
      #1 rst_in = 1'b0;
      falls(1);
      marker_reset_in = 1'b1;
      @(posedge clk_in);
      #1 marker_reset_in = 1'b0;
   endtask

   task automatic test_oe;
      check({11'h0, oe_n}, 12'h1, "bus driven before read");
      terms = 3'h7;
      repeat (5) @(posedge clk_in);
      #1 check({11'h0, oe_n}, 12'h0, "bus not driven");
      for (int i = 0; i < 3; i++)
      begin
         terms = 3'h7 & ~(3'h1 << i);
         repeat (6) @(posedge clk_in);
         #1 check({11'h0, oe_n}, 12'h1, "bus driven unselected");
      end
      terms = 3'h7;
   endtask

   task automatic test_latency;
      do_reset(2'h0);
      sample_codes_in[11:0] = 12'h123;
      falls(8);
      check(data, 12'h123, "single word");
      check({11'h0, mark_oe_n}, 12'h1, "marker enabled");
      sample_codes_in[11:0] = 12'h456;
      for (int k = 0; k < 5; k++)
      begin
         falls(1);
         check(data, 12'h123, "word too early");
      end
      falls(1);
      check(data, 12'h456, "word late");
   endtask

   task automatic test_coding;
      logic [11:0] codes [3] = '{12'hFFF, 12'h800, 12'h000};
      for (int tc = 0; tc < 2; tc++)
         for (int i = 0; i < 3; i++)
         begin
            twos_comp_in = tc[0];
            sample_codes_in[11:0] = codes[i];
            falls(7);
            check(data, tc ? {~codes[i][11], codes[i][10:0]} : codes[i], "coding");
         end
      twos_comp_in = 1'b0;
   endtask

   task automatic test_multi(input int n);
      int k;
      sample_codes_in = {12'h404, 12'h303, 12'h202, 12'h101};
      do_reset(2'(n - 1));
      k = 0;
      while (mark_n !== 1'b0 && k < 20)
      begin
         falls(1);
         k++;
      end
      check(12'(k), 12'(7 + n), "first marker");
      for (int j = 0; j < 2 * n; j++)
      begin
         check(data, 12'(12'h101 * (j % n + 1)), "channel order");
         check({11'h0, mark_n}, {11'h0, (j % n) != 0}, "marker");
         check({11'h0, mark_oe_n}, 12'h0, "marker disabled");
         falls(1);
      end
   endtask

   initial
   begin
      do_reset(2'h0);
      test_oe();
      test_latency();
      test_coding();
      for (int n = 2; n <= 4; n++)
         test_multi(n);
      end_sim();
   end
endmodule // multichannel_adc_output_sequencer_tb
